// File: src/fte_tx_encoder.sv
// 100 Mb/s transmit coding path: 4B/5B sequencing, serializer and code check
`timescale 1ns/1ps
`default_nettype none
module fte_tx_encoder
#(
    parameter int BIT_DIV = fte_pkg::BIT_DIV
)
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    input wire logic [3:0] txd_i,
    input wire logic scr_bypass_i,
    input wire logic [4:0] strap_address_pins_i,
    input wire logic chk_valid_i,
    input wire logic chk_in_data_i,
    input wire logic [4:0] chk_code_i,
    output logic nib_taken_o,
    output logic line_pos_o,
    output logic line_neg_o,
    output logic rx_er_o
);
    import fte_pkg::*;

    fte_line_if lnk ();

    logic [1:0] fill_cnt;
    logic [1:0] next_fill_cnt;
    logic [4:0] strap_s1_v;
    logic [4:0] strap_s2_v;
    logic [4:0] strap_s3_v;
    logic seed_done;
    logic [31:0] div_cnt;
    logic bit_en;
    logic [2:0] bit_cnt;
    logic [4:0] shreg;
    fte_state_e state;
    logic nib_taken;
    logic rx_er;
    logic seed_load;
    logic [31:0] next_div_cnt;
    logic next_bit_en;
    logic [2:0] next_bit_cnt;
    logic [4:0] next_shreg;
    fte_state_e next_state;
    logic next_nib_taken;
    logic next_rx_er;
    logic next_seed_done;
    logic slot_end;

    // Code check: invalid groups other than 10000 and 11001, halt, or control groups seen in data
    function automatic logic fte_bad(input logic [4:0] cg, input logic in_data);
        logic bad;
        bad = 1'b0;
        unique case (cg)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C: bad = 1'b1;
            CG_HALT: bad = 1'b1;
            CG_IDLE, CG_J, CG_K, CG_T, CG_R: bad = in_data;
            default: bad = 1'b0;
        endcase
        return bad;
    endfunction : fte_bad

    // Strap pins pass three flops; the seed is caught after reset release
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            fill_cnt <= 2'h0;
            strap_s1_v <= STRAP_RST;
            strap_s2_v <= STRAP_RST;
            strap_s3_v <= STRAP_RST;
        end
        else
        begin
            fill_cnt <= next_fill_cnt;
            strap_s1_v <= strap_address_pins_i;
            strap_s2_v <= strap_s1_v;
            strap_s3_v <= strap_s2_v;
        end
    end

    // Seed load once the chain holds pin values, not reset fill, and the later stages agree
    always_comb
    begin
        next_fill_cnt = (fill_cnt == SYNC_FILL) ? fill_cnt : fill_cnt + 2'h1;
        seed_load = !seed_done && (fill_cnt == SYNC_FILL) && (strap_s2_v == strap_s3_v);
        next_seed_done = seed_done | seed_load;
    end

    // Bit enable divider, serial slot counter and sequencer
    always_comb
    begin
        next_div_cnt = div_cnt;
        next_bit_en = 1'b0;
        if (div_cnt >= 32'(BIT_DIV - 1))
        begin
            next_div_cnt = 32'h0000_0000;
            next_bit_en = 1'b1;
        end
        else
        begin
            next_div_cnt = div_cnt + 32'h0000_0001;
        end
        slot_end = bit_en && (bit_cnt == BIT_LAST);
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_state = state;
        next_nib_taken = 1'b0;
        if (bit_en)
        begin
            next_bit_cnt = slot_end ? 3'h0 : bit_cnt + 3'h1;
            next_shreg = {shreg[3:0], 1'b0};
        end
        // New code-group chosen at each slot boundary
        if (slot_end)
        begin
            unique case (state)
                FTE_IDLE, FTE_ESD_R:
                begin
                    if (tx_en_i)
                    begin
                        next_state = FTE_SSD_J;
                        next_shreg = CG_J;
                        next_nib_taken = 1'b1;
                    end
                    else
                    begin
                        next_state = FTE_IDLE;
                        next_shreg = CG_IDLE;
                    end
                end
                FTE_SSD_J:
                begin
                    next_state = FTE_SSD_K;
                    next_shreg = CG_K;
                    next_nib_taken = 1'b1;
                end
                FTE_SSD_K, FTE_DATA:
                begin
                    if (tx_en_i)
                    begin
                        next_state = FTE_DATA;
                        next_shreg = tx_er_i ? CG_HALT : fte_enc(txd_i);
                        next_nib_taken = 1'b1;
                    end
                    else
                    begin
                        next_state = FTE_ESD_T;
                        next_shreg = CG_T;
                    end
                end
                FTE_ESD_T:
                begin
                    next_state = FTE_ESD_R;
                    next_shreg = CG_R;
                end
                default:
                begin
                    next_state = FTE_IDLE;
                    next_shreg = CG_IDLE;
                end
            endcase
        end
        next_rx_er = chk_valid_i && fte_bad(chk_code_i, chk_in_data_i);
    end

    // Register sequencer state
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            div_cnt <= 32'h0000_0000;
            bit_en <= 1'b0;
            bit_cnt <= 3'h0;
            shreg <= CG_IDLE;
            state <= FTE_IDLE;
            nib_taken <= 1'b0;
            rx_er <= 1'b0;
            seed_done <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            bit_en <= next_bit_en;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            state <= next_state;
            nib_taken <= next_nib_taken;
            rx_er <= next_rx_er;
            seed_done <= next_seed_done;
        end
    end

    // Serial bits leave MSB first toward the line coder
    assign lnk.bit_en = bit_en && seed_done;
    assign lnk.code_bit = shreg[4];
    assign lnk.bypass = scr_bypass_i;
    assign lnk.seed_load = seed_load;
    assign lnk.seed = {strap_s3_v[4:1], SEED_FILL};

    fte_line_coder u_coder
    (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .lnk(lnk.coder)
    );

    // Outputs
    assign nib_taken_o = nib_taken;
    assign line_pos_o = lnk.line_pos;
    assign line_neg_o = lnk.line_neg;
    assign rx_er_o = rx_er;
endmodule : fte_tx_encoder
`default_nettype wire

// File: src/fte_pkg.sv
// Shared constants and types for the fast ethernet transmit encoder
// Functional notes
// - Each data nibble maps to its fixed 5-bit code-group per the sixteen-entry table.
// - Frame start replaces first two preamble nibbles with J (11000) then K (10001).
// - Remaining preamble and data nibbles are sent as code-groups in received order.
// - On transmit enable falling, send T (01101) then R (00111).
// - After R, send IDLE 11111 continuously until transmit enable returns.
// - Code-group 00100 is HALT and marks an error in the stream.
// - Decode check flags invalid codes and control codes inside data, raising receive error; invalid 10000 and 11001 are not flagged.
// - Scrambler is an 11-bit closed-loop LFSR XORed with the serial NRZ bits.
// - Scrambler seed comes from strapped address bits [4:1].
// - A bypass setting skips the scrambler, feeding encoded bits straight to NRZI.
// - Scrambled serial stream is NRZI encoded before line coding.
// - MLT-3 splits NRZI into two streams with alternating one events.
// - Output carries only MLT-3 symbols; no plain binary output mode.
// - One 5-bit code-group per nibble slot, serialized one bit per bit enable.
// - Sequencing follows the standard idle, start, data, end transmit state machine.
`default_nettype none
package fte_pkg;
    localparam int LFSR_W = 11;
    localparam int CODE_W = 5;
    // Bit enable divider default: one serial bit per clock
    localparam int BIT_DIV = 1;
    localparam logic [2:0] BIT_LAST = 3'h4;
    // Control code-groups
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_HALT = 5'h04;
    // Low seed bits filled with ones so the LFSR never starts at zero
    localparam logic [6:0] SEED_FILL = 7'h7F;
    localparam logic [10:0] LFSR_RST = 11'h7FF;
    localparam logic [4:0] STRAP_RST = 5'h01;
    // Cycles for the strap synchroniser to fill with pin values after reset
    localparam logic [1:0] SYNC_FILL = 2'h3;
    // Transmit sequencing states, Gray coded along the frame path
    typedef enum logic [2:0]
    {
        FTE_IDLE = 3'b000,
        FTE_SSD_J = 3'b001,
        FTE_SSD_K = 3'b011,
        FTE_DATA = 3'b010,
        FTE_ESD_T = 3'b110,
        FTE_ESD_R = 3'b111
    } fte_state_e;
    // 4B to 5B data mapping
    function automatic logic [4:0] fte_enc(input logic [3:0] nib);
        logic [4:0] cg;
        cg = CG_IDLE;
        unique case (nib)
            4'h0: cg = 5'h1E;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0A;
            4'h5: cg = 5'h0B;
            4'h6: cg = 5'h0E;
            4'h7: cg = 5'h0F;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'hA: cg = 5'h16;
            4'hB: cg = 5'h17;
            4'hC: cg = 5'h1A;
            4'hD: cg = 5'h1B;
            4'hE: cg = 5'h1C;
            4'hF: cg = 5'h1D;
        endcase
        return cg;
    endfunction : fte_enc
endpackage : fte_pkg
`default_nettype wire

// File: src/fte_line_if.sv
// Signals between the code-group sequencer and the serial line coder
`timescale 1ns/1ps
`default_nettype none
interface fte_line_if;
    logic bit_en;
    logic code_bit;
    logic bypass;
    logic seed_load;
    logic [10:0] seed;
    logic line_pos;
    logic line_neg;
    modport seq (output bit_en, code_bit, bypass, seed_load, seed, input line_pos, line_neg);
    modport coder (input bit_en, code_bit, bypass, seed_load, seed, output line_pos, line_neg);
endinterface : fte_line_if
`default_nettype wire

// File: src/fte_line_coder.sv
// Serial scrambler, NRZI encoder and MLT-3 splitter
`timescale 1ns/1ps
`default_nettype none
module fte_line_coder
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    fte_line_if.coder lnk
);
    import fte_pkg::*;

    logic [10:0] lfsr;
    logic nrzi;
    logic [1:0] mlt;
    logic line_pos;
    logic line_neg;
    logic [10:0] next_lfsr;
    logic next_nrzi;
    logic [1:0] next_mlt;
    logic next_line_pos;
    logic next_line_neg;
    logic fb;
    logic nrz;

    // Next values for one serial bit
    always_comb
    begin
        fb = lfsr[10] ^ lfsr[8];
        nrz = lnk.bypass ? lnk.code_bit : (lnk.code_bit ^ fb);
        next_lfsr = lfsr;
        next_nrzi = nrzi;
        next_mlt = mlt;
        next_line_pos = line_pos;
        next_line_neg = line_neg;
        if (lnk.seed_load)
        begin
            next_lfsr = lnk.seed;
        end
        else if (lnk.bit_en)
        begin
            next_lfsr = {lfsr[9:0], fb};
            next_nrzi = nrzi ^ nrz;
            // MLT-3 walks 0, +, 0, - on each one of the NRZI stream
            if (next_nrzi)
            begin
                next_mlt = mlt + 2'h1;
            end
            next_line_pos = (next_mlt == 2'h1);
            next_line_neg = (next_mlt == 2'h3);
        end
    end

    // Register coder state
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            lfsr <= LFSR_RST;
            nrzi <= 1'b0;
            mlt <= 2'h0;
            line_pos <= 1'b0;
            line_neg <= 1'b0;
        end
        else
        begin
            lfsr <= next_lfsr;
            nrzi <= next_nrzi;
            mlt <= next_mlt;
            line_pos <= next_line_pos;
            line_neg <= next_line_neg;
        end
    end

    assign lnk.line_pos = line_pos;
    assign lnk.line_neg = line_neg;
endmodule : fte_line_coder
`default_nettype wire

// File: dv/fte_tx_encoder_chk.sv
// Port checker for the transmit encoder
`timescale 1ns/1ps
`default_nettype none
module fte_tx_encoder_chk
    import fte_pkg::*;
#(
    parameter int BIT_DIV = 1
)
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic tx_en_i,
    input wire logic tx_er_i,
    input wire logic [3:0] txd_i,
    input wire logic scr_bypass_i,
    input wire logic [4:0] strap_address_pins_i,
    input wire logic chk_valid_i,
    input wire logic chk_in_data_i,
    input wire logic [4:0] chk_code_i,
    input wire logic nib_taken_o,
    input wire logic line_pos_o,
    input wire logic line_neg_o,
    input wire logic rx_er_o
);
    localparam int SLOT = 5 * BIT_DIV;
    logic last_neg;
    logic next_last_neg;
    logic [7:0] gap;
    logic [7:0] next_gap;
    logic chk_bad;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Codes that must raise the error flag
    assign chk_bad = (chk_code_i inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, CG_HALT})
        || (chk_in_data_i && (chk_code_i inside {CG_IDLE, CG_J, CG_K, CG_T, CG_R}));
    // Last side driven, cycles since last take
    always_comb
    begin
        next_last_neg = line_neg_o | (last_neg & ~line_pos_o);
        next_gap = nib_taken_o ? 8'h01 : gap + {7'h00, gap != 8'hFF};
    end
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            last_neg <= 1'b1;
            gap <= 8'hFF;
        end
        else
        begin
            last_neg <= next_last_neg;
            gap <= next_gap;
        end
    end
    sequence s_bad_chk;
        chk_valid_i && chk_bad;
    endsequence
    sequence s_good_chk;
        chk_valid_i && !chk_bad;
    endsequence
    property p_bad_flag; s_bad_chk |=> rx_er_o; endproperty
    property p_halt_flag; chk_valid_i && chk_code_i == CG_HALT |=> rx_er_o; endproperty
    property p_good_quiet; s_good_chk |=> !rx_er_o; endproperty
    property p_er_cause; rx_er_o |-> $past(chk_valid_i); endproperty
    property p_one_side; !(line_pos_o && line_neg_o); endproperty
    property p_via_zero; line_pos_o |=> !line_neg_o; endproperty
    property p_alt_pos; $rose(line_pos_o) |-> last_neg; endproperty
    property p_alt_neg; $rose(line_neg_o) |-> !last_neg; endproperty
    property p_slot_gap; nib_taken_o |-> int'(gap) >= SLOT; endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("bad code not flagged");
    a_halt_flag: assert property (p_halt_flag) else $error("halt not flagged");
    a_good_quiet: assert property (p_good_quiet) else $error("good code flagged");
    a_er_cause: assert property (p_er_cause) else $error("error flag without check");
    a_one_side: assert property (p_one_side) else $error("both sides driven");
    a_via_zero: assert property (p_via_zero) else $error("side swap without zero");
    a_alt_pos: assert property (p_alt_pos) else $error("positive twice");
    a_alt_neg: assert property (p_alt_neg) else $error("negative twice");
    a_slot_gap: assert property (p_slot_gap) else $error("takes too close");
endmodule : fte_tx_encoder_chk
bind fte_tx_encoder fte_tx_encoder_chk #(.BIT_DIV(BIT_DIV)) chk_u
(
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .tx_en_i(tx_en_i), .tx_er_i(tx_er_i), .txd_i(txd_i),
    .scr_bypass_i(scr_bypass_i), .strap_address_pins_i(strap_address_pins_i), .chk_valid_i(chk_valid_i),
    .chk_in_data_i(chk_in_data_i), .chk_code_i(chk_code_i), .nib_taken_o(nib_taken_o),
    .line_pos_o(line_pos_o), .line_neg_o(line_neg_o), .rx_er_o(rx_er_o)
);
`default_nettype wire

// File: dv/fte_mac_model.sv
// Nibble source standing in for the MAC
`timescale 1ns/1ps
`default_nettype none
module fte_mac_model
(
    input wire logic mclk_i,
    input wire logic nib_taken_i,
    output logic tx_en_o,
    output logic tx_er_o,
    output logic [3:0] txd_o
);
    logic [3:0] frame_q[$];
    int idx = 0;
    int er_idx = -1;
    logic active = 1'b0;
    initial
    begin
        tx_en_o = 1'b0;
        tx_er_o = 1'b0;
        txd_o = 4'h0;
    end
    // Load a frame, preamble nibbles first
    task automatic send(input logic [3:0] nibs[$], input int er_at);
        frame_q = nibs;
        er_idx = er_at;
        idx = 0;
        active = 1'b1;
    endtask : send
    // Step on each take, drop enable after the last nibble
    always @(negedge mclk_i)
    begin
        if (active && nib_taken_i)
            idx = idx + 1;
        if (active && idx < frame_q.size())
        begin
            tx_en_o <= 1'b1;
            txd_o <= frame_q[idx];
            tx_er_o <= (idx == er_idx);
        end
        else
        begin
            active = 1'b0;
            tx_en_o <= 1'b0;
            tx_er_o <= 1'b0;
            txd_o <= ~txd_o; // No stale data once released
        end
    end
endmodule : fte_mac_model
`default_nettype wire

// File: dv/fte_tx_encoder_tb.sv
// Self-checking bench for the transmit encoder
`timescale 1ns/1ps
`default_nettype none
module fte_tx_encoder_tb;
    import fte_pkg::*;
    localparam logic [4:0] ENC[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic tx_en_i, tx_er_i, nib_taken_o, line_pos_o, line_neg_o, rx_er_o;
    logic [3:0] txd_i;
    logic scr_bypass_i = 1'b1;
    logic chk_valid_i = 1'b0;
    logic chk_in_data_i = 1'b0;
    logic [4:0] chk_code_i = 5'h00;
    logic [4:0] strap = 5'h16;
    logic [31:0] rng = 32'h0000_0028;
    logic [1:0] plvl = 2'h0;
    logic pnz = 1'b0;
    logic [9:0] win = 10'h000;
    int failures = 0;
    int checks_done = 0;
    int takes = 0;
    fte_tx_encoder #(.BIT_DIV(1)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .tx_en_i(tx_en_i),
        .tx_er_i(tx_er_i), .txd_i(txd_i), .scr_bypass_i(scr_bypass_i), .strap_address_pins_i(strap),
        .chk_valid_i(chk_valid_i), .chk_in_data_i(chk_in_data_i), .chk_code_i(chk_code_i),
        .nib_taken_o(nib_taken_o), .line_pos_o(line_pos_o), .line_neg_o(line_neg_o), .rx_er_o(rx_er_o));
    fte_mac_model mac_u (.mclk_i(mclk_i), .nib_taken_i(nib_taken_o), .tx_en_o(tx_en_i), .tx_er_o(tx_er_i),
        .txd_o(txd_i));
    always #5 mclk_i = ~mclk_i;
    // Recover code bits: a level step is an NRZI one, a change of that is a code one
    always @(negedge mclk_i)
    begin : mon
        logic nz;
        nz = ({line_neg_o, line_pos_o} != plvl);
        win = {win[8:0], nz ^ pnz};
        plvl = {line_neg_o, line_pos_o};
        pnz = nz;
        if (nib_taken_o)
            takes++;
    end
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd
    function automatic logic bad(input logic [4:0] c, input logic d);
        return (c inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, CG_HALT})
            || (d && (c inside {CG_IDLE, CG_J, CG_K, CG_T, CG_R}));
    endfunction : bad
    // Keystream expected from the strap seed, first bit in bit 0
    function automatic logic [31:0] seed_ks(input logic [4:0] st);
        logic [10:0] l;
        logic [31:0] e;
        l = {st[4:1], SEED_FILL};
        for (int n = 0; n < 32; n++)
        begin
            e[n] = l[10] ^ l[8];
            l = {l[9:0], e[n]};
        end
        return e;
    endfunction : seed_ks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic grab(output logic [4:0] g);
        repeat (5) @(negedge mclk_i);
        #1;
        g = win[4:0];
    endtask : grab
    task automatic frame(input int len, input int er_at, input logic rd);
        logic [3:0] q[$];
        logic [4:0] g;
        int n;
        for (int i = 0; i < len; i++)
            q.push_back(4'(rd ? rnd() : i));
        takes = 0;
        mac_u.send(q, er_at);
        n = 0;
        while (win != {CG_J, CG_K} && n < 300)
        begin
            @(negedge mclk_i);
            #1;
            n++;
        end
        check("start_delim", n < 300, 1);
        if (n >= 300)
            end_of_test();
        for (int i = 2; i < len; i++)
        begin
            grab(g);
            check("data_group", g, (i == er_at) ? CG_HALT : ENC[q[i]]);
        end
        grab(g);
        check("end_t", g, CG_T);
        grab(g);
        check("end_r", g, CG_R);
        repeat (2)
        begin
            grab(g);
            check("idle", g, CG_IDLE);
        end
        check("takes", takes, len);
    endtask : frame
    initial
    begin : main
        logic pv, pd;
        logic [4:0] pc;
        logic [10:0] h;
        logic ks;
        logic [47:0] obs;
        int hit;
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (10) @(negedge mclk_i);
        frame(2, -1, 1'b0);
        frame(18, -1, 1'b0);
        for (int r = 0; r < 5; r++)
            frame(3 + int'(rnd() % 20), (r == 1) ? 2 : -1, 1'b1);
        // Code check: every code both ways, then random back to back
        for (int k = 0; k < 105; k++)
        begin
            @(negedge mclk_i);
            if (k > 0)
                check("rx_er", rx_er_o, pv && bad(pc, pd));
            pv = (k < 64) || rnd() % 2;
            pc = (k < 64) ? k[4:0] : 5'(rnd());
            pd = (k < 64) ? k[5] : rnd() % 2;
            chk_valid_i <= pv;
            chk_code_i <= pc;
            chk_in_data_i <= pd;
        end
        // Scrambled idle: keystream must follow the 11/9 recurrence
        scr_bypass_i <= 1'b0;
        repeat (20) @(negedge mclk_i);
        for (int b = 0; b < 60; b++)
        begin
            @(negedge mclk_i);
            #1;
            ks = ~win[0];
            if (b >= 11)
                check("keystream", ks, h[10] ^ h[8]);
            h = {h[9:0], ks};
        end
        // Mid-run reset with new straps: scrambled idle must start from the strap seed
        @(negedge mclk_i);
        strap <= 5'(rnd());
        sys_rst_i <= 1'b1;
        repeat (3) @(negedge mclk_i);
        sys_rst_i <= 1'b0;
        for (int b = 0; b < 48; b++)
        begin
            @(negedge mclk_i);
            #1;
            obs[b] = ~win[0];
        end
        hit = 0;
        for (int o = 0; o < 16; o++)
            if (obs[o +: 32] == seed_ks(strap))
                hit = 1;
        check("seed_stream", hit, 1);
        end_of_test();
    end
endmodule : fte_tx_encoder_tb
`default_nettype wire
